// *** ide_defs.vh ***
// Operation
// RL1 - Decode and address work in stages 3-6
// RL2 - Capture fetch at stage 2, decode later
// RL3 - Data regs load at stages 2 and 7
// RL4 - Bus alternates opcode/disp and operand words
// RL5 - Instruction on bus stage 3, operand 8
// RL6 - Pair new opcode with previous displacement
// RL7 - 8K x 20 table gives entry points
// RL8 - Address reg loads on stage1 or microword clock
// RL9 - Register read addresses from opcode, latched stage4
// RL10 - Upper half from base or counter
// RL11 - Index and displacement adders form lower half
// RL12 - Full address loaded at end of stage6
// RL13 - Detect register collision, raise hold
// RL14 - Flags bit 2 extends table address
// RL15 - Control field tracks floating register use
// RL16 - Opcode valid on high half same beat
// RL17 - Return-to-fetch loads address within beat
// RL18 - Collision suppresses latch enable within beat
// RL19 - Control unit stalls stages during collision
// RL20 - Hold keeps address registers until written; memory_address_reg still loads on return_to_fetch, stage1 or microword clock
`ifndef IDE_DEFS_VH
`define IDE_DEFS_VH
`define IDE_WORD_W 32
`define IDE_HALF_W 16
`define IDE_TBL_AW 13
`define IDE_TBL_DW 20
`define IDE_FLAG_DP_BIT 2
`define IDE_ENTRY_W 18
`define IDE_CTL_FP_BIT 18
`define IDE_CTL_IDXEN_BIT 19
`define IDE_REG_AW 4
`define IDE_FIFO_DEPTH 8
`define IDE_MODE_BX 3'h0
`define IDE_MODE_PX 3'h1
`define IDE_MODE_BD 3'h2
`define IDE_MODE_PD 3'h3
`define IDE_MODE_BXD 3'h4
`define IDE_MODE_PXD 3'h5
`endif

// *** ide_fifo.v ***
`timescale 1ns/1ps
module ide_fifo #(
  parameter WIDTH = 32,
  parameter DEPTH = 8,
  parameter AW = 3
) (
  input wire clk,
  input wire rst,
  input wire [WIDTH-1:0] in_data,
  input wire in_valid,
  output wire in_ready,
  output wire [WIDTH-1:0] out_data,
  output wire out_valid,
  input wire out_ready
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wp_q;
  reg [AW-1:0] rd_idx_q;
  reg [AW:0] cnt_q;
  wire push;
  wire pop;
  assign in_ready = (cnt_q != DEPTH[AW:0]);
  assign out_valid = (cnt_q != {(AW+1){1'b0}});
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem[rd_idx_q];
  always @(posedge clk) begin
    if (push) begin
      mem[wp_q] <= in_data;
    end
  end
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      wp_q <= {AW{1'b0}};
      rd_idx_q <= {AW{1'b0}};
      cnt_q <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wp_q <= (wp_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wp_q + 1'b1;
      end
      if (pop) begin
        rd_idx_q <= (rd_idx_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_idx_q + 1'b1;
      end
      if (push && !pop) begin
        cnt_q <= cnt_q + 1'b1;
      end else if (pop && !push) begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end
endmodule

// *** ide_unit.v ***
`timescale 1ns/1ps
`include "ide_defs.vh"
module ide_unit #(
  parameter FIFO_DEPTH = `IDE_FIFO_DEPTH,
  parameter FIFO_AW = 3
) (
  input wire core_clk,
  input wire rst,
  input wire stage_one_clock,
  input wire stage_two_clock,
  input wire stage_seven_clock,
  input wire stage_three_en,
  input wire stage_four_en,
  input wire stage_five_en,
  input wire stage_six_en,
  input wire stage_eight_en,
  input wire microword_load_clock,
  input wire [31:0] cache_rd_data,
  input wire cache_rd_valid,
  output wire cache_rd_ready,
  input wire [31:0] fetch_addr,
  input wire [31:0] operand_addr,
  input wire return_to_fetch,
  input wire [31:0] true_program_counter,
  input wire [15:0] processor_flags_reg,
  input wire tbl_wr_en,
  input wire [12:0] tbl_wr_addr,
  input wire [19:0] tbl_wr_data,
  input wire [3:0] exec_dest_reg,
  input wire exec_dest_pending,
  input wire rf_wr_en,
  input wire [3:0] rf_wr_addr,
  input wire [31:0] rf_wr_data,
  output reg [31:0] shared_operand_bus,
  output reg bus_valid,
  output reg bus_is_operand,
  output reg [17:0] entry_point,
  output reg fp_reg_used,
  output reg [31:0] memory_address_reg,
  output reg [31:0] translation_buffer,
  output wire hold_request
);
  // ****************************************************************
  // Fetch formatting and data registers
  // ****************************************************************
  reg [31:0] cache_data_regs_q;
  reg cdr_is_op_q;
  reg cdr_full_q;
  reg [15:0] prev_disp_q;
  reg [15:0] cur_disp_q;
  wire [31:0] ff_data;
  wire ff_valid;
  wire ff_ready;
  wire cdr_load;
  wire [31:0] fetch_format_chip;
  // Data path is buffered so the cache may run ahead of bus beats.
  ide_fifo #(.WIDTH(32), .DEPTH(FIFO_DEPTH), .AW(FIFO_AW)) u_fifo (
    .clk(core_clk),
    .rst(rst),
    .in_data(cache_rd_data),
    .in_valid(cache_rd_valid),
    .in_ready(cache_rd_ready),
    .out_data(ff_data),
    .out_valid(ff_valid),
    .out_ready(ff_ready)
  );
  assign cdr_load = (stage_two_clock || stage_seven_clock) && ff_valid; // RL3
  assign ff_ready = stage_two_clock || stage_seven_clock;
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cache_data_regs_q <= 32'h00000000;
      cdr_is_op_q <= 1'b0;
      cdr_full_q <= 1'b0;
      prev_disp_q <= 16'h0000;
      cur_disp_q <= 16'h0000;
    end else if (cdr_load) begin
      cache_data_regs_q <= ff_data; // RL2
      cdr_is_op_q <= stage_seven_clock && !stage_two_clock;
      cdr_full_q <= 1'b1;
      if (stage_two_clock) begin
        prev_disp_q <= cur_disp_q; // RL6
        cur_disp_q <= ff_data[15:0];
      end
    end
  end
  // Opcode is steered combinationally so it is on the high half this beat.
  assign fetch_format_chip = cdr_is_op_q ? cache_data_regs_q :
    {cache_data_regs_q[31:16], prev_disp_q}; // RL6 RL16
  wire [15:0] shared_bus_high_half;
  wire [15:0] shared_bus_low_half;
  assign shared_bus_high_half = fetch_format_chip[31:16];
  assign shared_bus_low_half = fetch_format_chip[15:0];
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      shared_operand_bus <= 32'h00000000;
      bus_valid <= 1'b0;
      bus_is_operand <= 1'b0;
    end else begin
      bus_valid <= cdr_full_q && ((stage_three_en && !cdr_is_op_q) ||
        (stage_eight_en && cdr_is_op_q)); // RL4 RL5
      bus_is_operand <= cdr_is_op_q;
      shared_operand_bus <= {shared_bus_high_half, shared_bus_low_half};
    end
  end
  // ****************************************************************
  // Decode table
  // ****************************************************************
  reg [19:0] decode_tbl [0:8191];
  wire [12:0] tbl_addr;
  reg [15:0] opcode_q;
  // Flag bit doubles the usable table for the native entry points.
  assign tbl_addr = {processor_flags_reg[`IDE_FLAG_DP_BIT], opcode_q[11:0]}; // RL14
  always @(posedge core_clk) begin
    if (tbl_wr_en) begin
      decode_tbl[tbl_wr_addr] <= tbl_wr_data;
    end
  end
  reg [19:0] tbl_out_q;
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      opcode_q <= 16'h0000;
      tbl_out_q <= 20'h00000;
      entry_point <= 18'h00000;
      fp_reg_used <= 1'b0;
    end else begin
      if (stage_three_en && !cdr_is_op_q) begin
        opcode_q <= shared_bus_high_half; // RL1
      end
      if (stage_four_en) begin
        tbl_out_q <= decode_tbl[tbl_addr]; // RL7
      end
      entry_point <= tbl_out_q[`IDE_ENTRY_W-1:0]; // RL7
      fp_reg_used <= tbl_out_q[`IDE_CTL_FP_BIT]; // RL15
    end
  end
  // ****************************************************************
  // Effective address formation
  // ****************************************************************
  reg [31:0] reg_file [0:15];
  reg [3:0] base_sel_q;
  reg [3:0] idx_sel_q;
  reg [2:0] mode_q;
  reg [15:0] disp_q;
  reg [31:0] ea_q;
  wire [3:0] base_sel_d;
  wire [3:0] idx_sel_d;
  wire [31:0] base_val;
  wire [15:0] idx_val;
  wire pc_rel;
  wire use_idx;
  wire use_disp;
  wire [15:0] idx_sum;
  wire [15:0] disp_sum;
  wire [31:0] ea_d;
  wire collision;
  always @(posedge core_clk) begin
    if (rf_wr_en) begin
      reg_file[rf_wr_addr] <= rf_wr_data;
    end
  end
  assign base_sel_d = opcode_q[7:4]; // RL9
  assign idx_sel_d = opcode_q[3:0]; // RL9
  assign base_val = reg_file[base_sel_q];
  assign idx_val = reg_file[idx_sel_q][15:0];
  assign pc_rel = mode_q[0];
  assign use_idx = (mode_q == `IDE_MODE_BX) || (mode_q == `IDE_MODE_PX) ||
    (mode_q == `IDE_MODE_BXD) || (mode_q == `IDE_MODE_PXD);
  assign use_disp = (mode_q == `IDE_MODE_BD) || (mode_q == `IDE_MODE_PD) ||
    (mode_q == `IDE_MODE_BXD) || (mode_q == `IDE_MODE_PXD);
  wire [15:0] low_src;
  assign low_src = pc_rel ? true_program_counter[15:0] : base_val[15:0];
  assign idx_sum = low_src + (use_idx ? idx_val : 16'h0000); // RL11
  assign disp_sum = idx_sum + (use_disp ? disp_q : 16'h0000); // RL11
  assign ea_d = {(pc_rel ? true_program_counter[31:16] : base_val[31:16]),
    disp_sum}; // RL10
  // Collision check is combinational so latch enables drop in the same beat.
  assign collision = exec_dest_pending && !(rf_wr_en && rf_wr_addr == exec_dest_reg) &&
    ((exec_dest_reg == base_sel_q && !pc_rel) ||
    (exec_dest_reg == idx_sel_q && use_idx)); // RL13
  assign hold_request = collision; // RL13 RL19
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      base_sel_q <= 4'h0;
      idx_sel_q <= 4'h0;
      mode_q <= 3'h0;
      disp_q <= 16'h0000;
      ea_q <= 32'h00000000;
    end else begin
      if (stage_four_en && !collision) begin
        base_sel_q <= base_sel_d; // RL9 RL20
        idx_sel_q <= idx_sel_d;
        mode_q <= opcode_q[10:8];
        disp_q <= prev_disp_q;
      end
      if (stage_five_en && !collision) begin
        ea_q <= ea_d; // RL18 RL20
      end
    end
  end
  // ****************************************************************
  // Cache and translation address registers
  // ****************************************************************
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      memory_address_reg <= 32'h00000000;
      translation_buffer <= 32'h00000000;
    end else begin
      if (return_to_fetch || stage_one_clock) begin
        memory_address_reg <= fetch_addr; // RL8 RL17
      end else if (stage_six_en && !collision) begin
        memory_address_reg <= ea_q; // RL12
        translation_buffer <= ea_q; // RL12
      end else if (microword_load_clock) begin
        memory_address_reg <= operand_addr; // RL8
      end
    end
  end
endmodule

// *** ide_cache_model.sv ***
`timescale 1ns/1ps
module ide_cache_model (
  input wire logic core_clk,
  input wire logic cache_rd_ready,
  output logic [31:0] cache_rd_data,
  output logic cache_rd_valid
);
  initial begin
    cache_rd_valid = 1'b0;
    cache_rd_data = 32'h0;
  end
  // Idle data is inverted so a stale word can never pass for a fresh one.
  task automatic push(input logic [31:0] w);
    @(negedge core_clk);
    cache_rd_data = w;
    cache_rd_valid = 1'b1;
    @(posedge core_clk);
    while (cache_rd_ready !== 1'b1) @(posedge core_clk);
    @(negedge core_clk);
    cache_rd_valid = 1'b0;
    cache_rd_data = ~w;
  endtask
endmodule

// *** ide_unit_props.sv ***
`timescale 1ns/1ps
module ide_unit_props (
  input wire core_clk,
  input wire rst,
  input wire stage_one_clock,
  input wire stage_three_en,
  input wire stage_eight_en,
  input wire microword_load_clock,
  input wire stage_six_en,
  input wire return_to_fetch,
  input wire [31:0] fetch_addr,
  input wire [31:0] operand_addr,
  input wire exec_dest_pending,
  input wire [3:0] exec_dest_reg,
  input wire rf_wr_en,
  input wire [3:0] rf_wr_addr,
  input wire bus_valid,
  input wire bus_is_operand,
  input wire [31:0] memory_address_reg,
  input wire [31:0] translation_buffer,
  input wire hold_request
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  wire other_ld = return_to_fetch | stage_one_clock | microword_load_clock;
  chk_bus_instr_word: assert property (bus_valid && !bus_is_operand |-> $past(stage_three_en))
    else $error("instruction word without stage three");
  chk_bus_oper_word: assert property (bus_valid && bus_is_operand |-> $past(stage_eight_en))
    else $error("operand word without stage eight");
  chk_hold_cause: assert property (hold_request |->
    exec_dest_pending && !(rf_wr_en && rf_wr_addr == exec_dest_reg))
    else $error("hold without pending result");
  chk_fetch_load: assert property (return_to_fetch |=> memory_address_reg == $past(fetch_addr))
    else $error("fetch address not loaded");
  chk_stage_one_load: assert property (stage_one_clock |=> memory_address_reg == $past(fetch_addr))
    else $error("stage one load wrong");
  chk_operand_load: assert property (microword_load_clock && !return_to_fetch && !stage_one_clock
    && !stage_six_en |=> memory_address_reg == $past(operand_addr))
    else $error("operand address not loaded");
  chk_mar_hold: assert property (hold_request && !other_ld |=> $stable(memory_address_reg))
    else $error("address register moved during hold");
  chk_tlb_hold: assert property (hold_request && !other_ld |=> $stable(translation_buffer))
    else $error("translation address moved during hold");
  cover property (bus_valid && bus_is_operand);
  cover property (hold_request ##1 !hold_request);
  cover property (return_to_fetch);
endmodule
bind ide_unit ide_unit_props i_ide_unit_props (.core_clk(core_clk), .rst(rst),
  .stage_one_clock(stage_one_clock), .stage_three_en(stage_three_en),
  .stage_eight_en(stage_eight_en), .microword_load_clock(microword_load_clock),
  .stage_six_en(stage_six_en), .return_to_fetch(return_to_fetch), .fetch_addr(fetch_addr),
  .operand_addr(operand_addr), .exec_dest_pending(exec_dest_pending),
  .exec_dest_reg(exec_dest_reg), .rf_wr_en(rf_wr_en), .rf_wr_addr(rf_wr_addr), .bus_valid(bus_valid),
  .bus_is_operand(bus_is_operand), .memory_address_reg(memory_address_reg),
  .translation_buffer(translation_buffer), .hold_request(hold_request));

// *** testbench.sv ***
`timescale 1ns/1ps
module testbench;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic [8:0] stg = 9'h0;
  logic rtf = 1'b0, te = 1'b0, dp = 1'b0, rfe = 1'b0;
  logic [31:0] fa = 32'h0, oa = 32'h0, pc = 32'hCAFE_0100, rfd = 32'h0;
  logic [15:0] flg = 16'h0;
  logic [12:0] ta = 13'h0;
  logic [19:0] td = 20'h0;
  logic [3:0] dr = 4'h0, rfa = 4'h0;
  wire rdy, vld, bv, bo, fp, hold;
  wire [31:0] cd, bus, mar, tlb;
  wire [17:0] ep;
  int n_fail = 0, tests_run = 0;
  always #5 core_clk = ~core_clk;
  ide_cache_model i_ide_cache_model (.core_clk(core_clk), .cache_rd_ready(rdy),
    .cache_rd_data(cd), .cache_rd_valid(vld));
  ide_unit i_ide_unit (.core_clk(core_clk), .rst(rst), .stage_one_clock(stg[0]),
    .stage_two_clock(stg[1]), .stage_seven_clock(stg[2]), .stage_three_en(stg[3]),
    .stage_four_en(stg[4]), .stage_five_en(stg[5]), .stage_six_en(stg[6]),
    .stage_eight_en(stg[7]), .microword_load_clock(stg[8]), .cache_rd_data(cd),
    .cache_rd_valid(vld), .cache_rd_ready(rdy), .fetch_addr(fa), .operand_addr(oa),
    .return_to_fetch(rtf), .true_program_counter(pc), .processor_flags_reg(flg),
    .tbl_wr_en(te), .tbl_wr_addr(ta), .tbl_wr_data(td), .exec_dest_reg(dr),
    .exec_dest_pending(dp), .rf_wr_en(rfe), .rf_wr_addr(rfa), .rf_wr_data(rfd),
    .shared_operand_bus(bus), .bus_valid(bv), .bus_is_operand(bo), .entry_point(ep),
    .fp_reg_used(fp), .memory_address_reg(mar), .translation_buffer(tlb), .hold_request(hold));
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      n_fail++;
      $display("unexpected %s: expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic pulse(input int i);
    @(negedge core_clk);
    stg = 9'h1 << i;
    @(negedge core_clk);
    stg = 9'h0;
  endtask
  task automatic rf_wr(input logic [3:0] a, input logic [31:0] d);
    @(negedge core_clk);
    {rfe, rfa, rfd} = {1'b1, a, d};
    @(negedge core_clk);
    rfe = 1'b0;
  endtask
  task automatic fetch(input logic [31:0] w);
    i_ide_cache_model.push(w);
    pulse(1);
    pulse(3);
  endtask
  task automatic t_fifo();
    for (int k = 0; k < 8; k++) i_ide_cache_model.push(32'h100 + k);
    chk("ready full", 32'h0, {31'h0, rdy});
    for (int k = 0; k < 8; k++) pulse(1);
    chk("ready empty", 32'h1, {31'h0, rdy});
  endtask
  task automatic t_stream();
    fetch(32'hA123_1111);
    fetch(32'hB045_2222);
    chk("instr bus", 32'hB045_1111, bus);
    chk("instr valid", 32'h1, {30'h0, bo, bv});
    i_ide_cache_model.push(32'h5A5A_C3C3);
    pulse(2);
    pulse(7);
    chk("operand bus", 32'h5A5A_C3C3, bus);
    chk("operand valid", 32'h3, {30'h0, bo, bv});
  endtask
  task automatic t_decode(input logic f, input logic [19:0] d);
    @(negedge core_clk);
    {te, ta, td, flg[2]} = {1'b1, f, 12'h123, d, f};
    @(negedge core_clk);
    te = 1'b0;
    fetch(32'h0123_0000);
    pulse(4);
    repeat (2) @(negedge core_clk);
    chk("entry", {14'h0, d[17:0]}, {14'h0, ep});
    chk("fp use", {31'h0, d[18]}, {31'h0, fp});
  endtask
  task automatic t_ea(input logic [31:0] w, input logic [31:0] e);
    fetch(w);
    pulse(4);
    pulse(5);
    pulse(6);
    chk("tlb addr", e, tlb);
    chk("mar addr", e, mar);
  endtask
  task automatic t_hold();
    fetch(32'h0023_0000);
    @(negedge core_clk);
    {dr, dp} = {4'h2, 1'b1};
    pulse(4);
    chk("hold", 32'h1, {31'h0, hold});
    pulse(5);
    pulse(6);
    chk("tlb held", 32'hCAFE_0110, tlb);
    chk("mar held", 32'hCAFE_0110, mar);
    rf_wr(4'h2, 32'h0100_0001);
    dp = 1'b0;
    @(negedge core_clk);
    chk("hold off", 32'h0, {31'h0, hold});
    t_ea(32'h0023_0000, 32'h0100_0011);
  endtask
  task automatic t_reset();
    @(negedge core_clk);
    rst = 1'b1;
    repeat (2) @(negedge core_clk);
    rst = 1'b0;
    chk("mar rerun", 32'h0, mar);
    chk("tlb rerun", 32'h0, tlb);
    chk("entry rerun", 32'h0, {14'h0, ep});
    @(negedge core_clk);
    chk("valid rerun", 32'h0, {30'h0, bo, bv});
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    #100000;
    n_fail++;
    finish_test();
  end
  initial begin
    repeat (5) @(negedge core_clk);
    rst = 1'b0;
    chk("mar reset", 32'h0, mar);
    chk("bus reset", 32'h0, {bus[30:0], bv});
    t_fifo();
    t_stream();
    t_decode(1'b0, 20'h0_ABCD);
    t_decode(1'b1, 20'h5_1234);
    rf_wr(4'h2, 32'h1234_5678);
    rf_wr(4'h3, 32'h0000_0010);
    t_ea(32'h0023_0040, 32'h1234_5688);
    t_ea(32'h0223_0080, 32'h1234_56B8);
    t_ea(32'h0323_0100, 32'hCAFE_0180);
    t_ea(32'h0423_0200, 32'h1234_5788);
    t_ea(32'h0523_0000, 32'hCAFE_0310);
    t_ea(32'h0123_0000, 32'hCAFE_0110);
    t_hold();
    t_reset();
    {fa, oa} = {32'h0000_4000, 32'h00AB_CDEF};
    @(negedge core_clk);
    rtf = 1'b1;
    @(negedge core_clk);
    rtf = 1'b0;
    chk("rtf mar", 32'h0000_4000, mar);
    pulse(8);
    chk("microword mar", 32'h00AB_CDEF, mar);
    fa = 32'h0000_4004;
    pulse(0);
    chk("stage one mar", 32'h0000_4004, mar);
    finish_test();
  end
endmodule
